//--- common/shi_map.vh
// register map, command codes, field positions and timing constants
`ifndef SHI_MAP_VH
`define SHI_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SHI_REG_IF        8'h1A
`define SHI_REG_ODR       8'h1D
`define SHI_REG_CFG       8'h1F
`define SHI_REG_CMD       8'h7E

// ----------------------------------------
// command codes
// ----------------------------------------
`define SHI_CMD_FLUSH     8'hB0
`define SHI_CMD_SRST      8'hB6

// ----------------------------------------
// field positions
// ----------------------------------------
`define SHI_IIR_LSB       1
`define SHI_IIR_MSB       3
`define SHI_SPI3_BIT      0

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SHI_ODR_RST       5'h00
`define SHI_ODR_MAX       5'h11
`define SHI_IIR_RST       3'h0
`define SHI_SPI3_RST      1'b0
`define SHI_I2C_ADDR_HI   6'h3B
`define SHI_PIN_RST       4'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define SHI_BASE_PERIOD_MS 5
`define SHI_CLK_MHZ        100

`endif

//--- src/shi_sync.v
// three-stage pin synchroniser with agreement filter
`include "shi_map.vh"
module shi_sync (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rstn,
  // raw pins and filtered levels
  input  wire [3:0] pin_async,
  output reg  [3:0] pin_q
);

  reg [3:0] s1;
  reg [3:0] s2;
  reg [3:0] s3;

  // ----------------------------------------
  // capture and filter
  // ----------------------------------------
  // a level counts only once stages two and three agree
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1    <= `SHI_PIN_RST;
      s2    <= `SHI_PIN_RST;
      s3    <= `SHI_PIN_RST;
      pin_q <= `SHI_PIN_RST;
    end
    else
    begin
      s1    <= pin_async;
      s2    <= s1;
      s3    <= s2;
      pin_q <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pin_q);
    end
  end

endmodule

//--- src/shi_top.v
// host interface and configuration registers of the pressure sensor
// Operation
// - rate code 0 gives 5 ms period, each step doubles it, up to code 0x11
// - filter code 000 bypasses, codes 001..111 give coefficients 1 to 127
// - command register always reads back as zero
// - queue-clear command empties the queue, leaves its settings alone
// - full reinit command returns all user settings to their defaults
// - device is only ever a slave on both serial interfaces
// - spi modes 00 and 11 accepted in both 4-wire and 3-wire wiring
// - multi-byte write is address and data pairs, each data stored at its address
// - multi-byte read starts at one address and increments after each byte
// - chip select high means i2c active, chip select low means spi
// - once chip select went low, i2c stays off until power-on reset
// - i2c slave serves standard, fast and high-speed transfers
// - i2c address has six fixed upper bits, lowest bit from select pin
// - answer at 0x76 with select pin low, 0x77 with it high
// - in i2c the clock pin is scl, data pin is sda pulled only low
// - spi first byte: top bit read flag, low seven bits the address
// - spi mode chosen from clock level just after chip select falls
// - i2c read: address written, restart or stop, then read until nack
// - spi read: one dummy byte follows the control byte before data
`include "shi_map.vh"

module shi_top #(
  parameter BASE_CYC = `SHI_BASE_PERIOD_MS * `SHI_CLK_MHZ * 1000
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // serial pins
  input  wire        serial_clk_pin,
  input  wire        serial_data_pin_i,
  output reg         serial_data_pin_o,
  output reg         serial_data_pin_oe,
  input  wire        chip_select_pin,
  input  wire        address_select_pin_i,
  output reg         address_select_pin_o,
  output reg         address_select_pin_oe,
  // settings towards the measurement core
  output reg  [17:0] odr_prescale,
  output reg         sample_tick,
  output reg  [6:0]  iir_coef,
  output reg         iir_bypass,
  output reg         fifo_flush,
  output reg         cfg_reset,
  // interface status
  output reg         i2c_locked,
  output reg         spi_mode_11,
  output reg         spi3_mode
);

  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_RX   = 3'h1;
  localparam [2:0] I_ACK  = 3'h2;
  localparam [2:0] I_TX   = 3'h3;
  localparam [2:0] I_MACK = 3'h4;

  localparam [1:0] R_SLV  = 2'h0;
  localparam [1:0] R_REG  = 2'h1;
  localparam [1:0] R_DAT  = 2'h2;

  // base counter is 20 bits, enough for the 5 ms base at 100 MHz
  localparam [31:0] BASE_LAST_W = BASE_CYC - 1;
  localparam [19:0] BASE_LAST   = BASE_LAST_W[19:0];

  wire [3:0] pin_q;
  wire       scl;
  wire       sda;
  wire       csn;
  wire       adsel;
  reg        scl_d;
  reg        sda_d;
  reg        csn_d;

  reg  [4:0]  odr_sel;
  reg  [2:0]  iir_sel;
  reg  [19:0] base_cnt;
  reg  [17:0] pre_cnt;

  reg  [2:0] i_st;
  reg  [1:0] i_role;
  reg  [3:0] i_cnt;
  reg  [7:0] i_sh;
  reg  [7:0] i_tx;
  reg  [7:0] i_ptr;
  reg        i_rw;
  reg        i_mack;
  reg        i_low;
  reg        i_wr;
  reg  [7:0] i_wa;
  reg  [7:0] i_wd;

  reg  [2:0] s_cnt;
  reg  [7:0] s_sh;
  reg  [7:0] s_tx;
  reg  [6:0] s_ptr;
  reg  [1:0] s_byte;
  reg        s_rw;
  reg        s_out;
  reg        s_drv;
  reg        s_wr;
  reg  [7:0] s_wa;
  reg  [7:0] s_wd;

  // ----------------------------------------
  // register read and write helpers
  // ----------------------------------------
  function [7:0] rd_reg;
    input [7:0] a;
    begin
      case (a)
        `SHI_REG_ODR: rd_reg = {3'h0, odr_sel};
        `SHI_REG_IF:  rd_reg = {7'h00, spi3_mode};
        `SHI_REG_CFG: rd_reg = {4'h0, iir_sel, 1'b0};
        `SHI_REG_CMD: rd_reg = 8'h00;
        default:      rd_reg = 8'h00;
      endcase
    end
  endfunction

  // rate codes above the top entry saturate
  function [4:0] odr_sat;
    input [7:0] v;
    begin
      odr_sat = (v > {3'h0, `SHI_ODR_MAX}) ? `SHI_ODR_MAX : v[4:0];
    end
  endfunction

  // ----------------------------------------
  // pin sampling and edges
  // ----------------------------------------
  // oversampled pins, all i2c speeds
  shi_sync u_sync (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .pin_async ({address_select_pin_i, chip_select_pin, serial_data_pin_i, serial_clk_pin}),
    .pin_q     (pin_q)
  );

  assign scl   = pin_q[0];
  assign sda   = pin_q[1];
  assign csn   = pin_q[2];
  assign adsel = pin_q[3];

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire cs_fall  = ~csn & csn_d;
  wire i2c_en    = ~i2c_locked & csn;
  wire i2c_start = i2c_en & scl & scl_d & sda_d & ~sda;
  wire i2c_stop  = i2c_en & scl & scl_d & ~sda_d & sda;

  wire [7:0] i_rd = rd_reg(i_ptr);
  wire [7:0] s_nb = {s_sh[6:0], sda};

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_d       <= 1'b1;
      sda_d       <= 1'b1;
      csn_d       <= 1'b1;
      i2c_locked  <= 1'b0;
      spi_mode_11 <= 1'b0;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
      csn_d <= csn;
      // a low select at any time locks i2c out until reset
      if (!csn)
        i2c_locked <= 1'b1;
      if (cs_fall)
        spi_mode_11 <= scl;
    end
  end

  // ----------------------------------------
  // configuration registers and commands
  // ----------------------------------------
  wire       wr_go = i_wr | s_wr;
  wire [7:0] wr_a  = i_wr ? i_wa : s_wa;
  wire [7:0] wr_d  = i_wr ? i_wd : s_wd;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      odr_sel    <= `SHI_ODR_RST;
      iir_sel    <= `SHI_IIR_RST;
      spi3_mode  <= `SHI_SPI3_RST;
      fifo_flush <= 1'b0;
      cfg_reset  <= 1'b0;
    end
    else
    begin
      fifo_flush <= 1'b0;
      cfg_reset  <= 1'b0;
      if (wr_go)
      begin
        case (wr_a)
          `SHI_REG_ODR: odr_sel   <= odr_sat(wr_d);
          `SHI_REG_IF:  spi3_mode <= wr_d[`SHI_SPI3_BIT];
          `SHI_REG_CFG: iir_sel   <= wr_d[`SHI_IIR_MSB:`SHI_IIR_LSB];
          `SHI_REG_CMD:
          begin
            if (wr_d == `SHI_CMD_FLUSH)
              fifo_flush <= 1'b1;
            else if (wr_d == `SHI_CMD_SRST)
            begin
              odr_sel   <= `SHI_ODR_RST;
              iir_sel   <= `SHI_IIR_RST;
              spi3_mode <= `SHI_SPI3_RST;
              cfg_reset <= 1'b1;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // rate and filter decode, sample timer
  // ----------------------------------------
  // timer is not restarted on a rate change; a prescale already passed ticks at the next base wrap
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      odr_prescale <= 18'h0_0001;
      iir_coef     <= 7'h00;
      iir_bypass   <= 1'b1;
      base_cnt     <= 20'h0_0000;
      pre_cnt      <= 18'h0_0000;
      sample_tick  <= 1'b0;
    end
    else
    begin
      odr_prescale <= 18'h0_0001 << odr_sel;
      // coefficient two to the code minus one
      iir_coef     <= (7'h01 << iir_sel) - 7'h01;
      iir_bypass   <= (iir_sel == 3'h0);
      sample_tick  <= 1'b0;
      if (base_cnt == BASE_LAST)
      begin
        base_cnt <= 20'h0_0000;
        if (pre_cnt >= odr_prescale - 18'h0_0001)
        begin
          pre_cnt     <= 18'h0_0000;
          sample_tick <= 1'b1;
        end
        else
          pre_cnt <= pre_cnt + 18'h0_0001;
      end
      else
        base_cnt <= base_cnt + 20'h0_0001;
    end
  end

  // ----------------------------------------
  // i2c slave
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      i_st   <= I_IDLE;
      i_role <= R_SLV;
      i_cnt  <= 4'h0;
      i_sh   <= 8'h00;
      i_tx   <= 8'h00;
      i_ptr  <= 8'h00;
      i_rw   <= 1'b0;
      i_mack <= 1'b0;
      i_low  <= 1'b0;
      i_wr   <= 1'b0;
      i_wa   <= 8'h00;
      i_wd   <= 8'h00;
    end
    else
    begin
      i_wr <= 1'b0;
      if (!i2c_en)
      begin
        i_st  <= I_IDLE;
        i_low <= 1'b0;
      end
      else if (i2c_start)
      begin
        i_st   <= I_RX;
        i_role <= R_SLV;
        i_cnt  <= 4'h0;
        i_low  <= 1'b0;
      end
      else if (i2c_stop)
      begin
        i_st  <= I_IDLE;
        i_low <= 1'b0;
      end
      else
      begin
        case (i_st)
          I_RX:
          begin
            if (scl_rise)
            begin
              i_sh  <= {i_sh[6:0], sda};
              i_cnt <= i_cnt + 4'h1;
            end
            else if (scl_fall && i_cnt == 4'h8)
            begin
              i_cnt <= 4'h0;
              case (i_role)
                R_SLV:
                begin
                  // fixed upper bits, pin low bit
                  if (i_sh[7:1] == {`SHI_I2C_ADDR_HI, adsel})
                  begin
                    i_rw  <= i_sh[0];
                    i_low <= 1'b1;
                    i_st  <= I_ACK;
                  end
                  else
                    i_st <= I_IDLE;
                end
                R_REG:
                begin
                  i_ptr <= i_sh;
                  i_low <= 1'b1;
                  i_st  <= I_ACK;
                end
                default:
                begin
                  i_wa  <= i_ptr;
                  i_wd  <= i_sh;
                  i_wr  <= 1'b1;
                  i_low <= 1'b1;
                  i_st  <= I_ACK;
                end
              endcase
            end
          end
          I_ACK:
          begin
            if (scl_fall)
            begin
              if (i_role == R_SLV && i_rw)
              begin
                i_tx  <= {i_rd[6:0], 1'b0};
                i_low <= ~i_rd[7];
                i_st  <= I_TX;
              end
              else
              begin
                i_low  <= 1'b0;
                i_st   <= I_RX;
                i_role <= (i_role == R_REG) ? R_DAT : R_REG;
              end
            end
          end
          I_TX:
          begin
            if (scl_rise)
              i_cnt <= i_cnt + 4'h1;
            else if (scl_fall)
            begin
              if (i_cnt == 4'h8)
              begin
                i_ptr <= i_ptr + 8'h01;
                i_low <= 1'b0;
                i_cnt <= 4'h0;
                i_st  <= I_MACK;
              end
              else
              begin
                i_low <= ~i_tx[7];
                i_tx  <= {i_tx[6:0], 1'b0};
              end
            end
          end
          I_MACK:
          begin
            if (scl_rise)
              i_mack <= ~sda;
            else if (scl_fall)
            begin
              if (i_mack)
              begin
                i_tx  <= {i_rd[6:0], 1'b0};
                i_low <= ~i_rd[7];
                i_st  <= I_TX;
              end
              else
                i_st <= I_IDLE;
            end
          end
          default: i_st <= I_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // spi slave
  // ----------------------------------------
  // sampling on rising and driving on falling edges suits both modes
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_cnt  <= 3'h0;
      s_sh   <= 8'h00;
      s_tx   <= 8'h00;
      s_ptr  <= 7'h00;
      s_byte <= 2'h0;
      s_rw   <= 1'b0;
      s_out  <= 1'b0;
      s_drv  <= 1'b0;
      s_wr   <= 1'b0;
      s_wa   <= 8'h00;
      s_wd   <= 8'h00;
    end
    else
    begin
      s_wr <= 1'b0;
      if (csn)
      begin
        s_cnt  <= 3'h0;
        s_byte <= 2'h0;
        s_drv  <= 1'b0;
      end
      else if (scl_rise)
      begin
        s_sh  <= s_nb;
        s_cnt <= s_cnt + 3'h1;
        if (s_cnt == 3'h7)
        begin
          case (s_byte)
            2'h0:
            begin
              s_rw   <= s_nb[7];
              s_ptr  <= s_nb[6:0];
              s_byte <= 2'h1;
            end
            2'h1:
            begin
              if (s_rw)
              begin
                s_tx   <= rd_reg({1'b0, s_ptr});
                s_byte <= 2'h2;
              end
              else
              begin
                s_wa   <= {1'b0, s_ptr};
                s_wd   <= s_nb;
                s_wr   <= 1'b1;
                s_byte <= 2'h0;
              end
            end
            default:
            begin
              s_ptr <= s_ptr + 7'h01;
              s_tx  <= rd_reg({1'b0, s_ptr + 7'h01});
            end
          endcase
        end
      end
      else if (scl_fall)
      begin
        s_out <= s_tx[7];
        s_tx  <= {s_tx[6:0], 1'b0};
        if (s_rw && s_byte == 2'h2)
          s_drv <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  // pins driven only in answer to the host
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_data_pin_o     <= 1'b0;
      serial_data_pin_oe    <= 1'b0;
      address_select_pin_o  <= 1'b0;
      address_select_pin_oe <= 1'b0;
    end
    else
    begin
      serial_data_pin_o     <= i_low ? 1'b0 : s_out;
      serial_data_pin_oe    <= i_low | (spi3_mode & s_drv);
      address_select_pin_o  <= s_out;
      address_select_pin_oe <= ~spi3_mode & s_drv;
    end
  end

endmodule

//--- sim/shi_top_sva.sv
// concurrent checks on the host interface block ports
module shi_top_sva #(
  parameter BASE_CYC = 10
) (
  // clock and reset
  input wire        clk_sys,
  input wire        rstn,
  // pins
  input wire        chip_select_pin,
  input wire        serial_data_pin_o,
  input wire        serial_data_pin_oe,
  input wire        address_select_pin_oe,
  // settings and status
  input wire [17:0] odr_prescale,
  input wire [6:0]  iir_coef,
  input wire        iir_bypass,
  input wire        fifo_flush,
  input wire        cfg_reset,
  input wire        i2c_locked,
  input wire        spi3_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ------
  // sequences
  // ------
  sequence csn_held;
    !chip_select_pin [*8];
  endsequence
  sequence back_to_defaults;
    iir_bypass && (odr_prescale == 18'h0_0001) && !spi3_mode;
  endsequence
  sequence settings_still;
    ($stable(iir_coef) && $stable(odr_prescale)) [*3];
  endsequence
  // ------
  // assertions
  // ------
  chk_rate_onehot: assert property ($onehot(odr_prescale))
    else $error("rate prescale is not a single power of two");
  chk_filter_code: assert property ((((iir_coef + 7'h01) & iir_coef) == 7'h00)
    && (iir_bypass == (iir_coef == 7'h00)))
    else $error("filter coefficient or bypass out of step");
  chk_flush_pulse: assert property (fifo_flush |=> !fifo_flush and settings_still)
    else $error("queue clear not a single pulse or settings moved");
  chk_defaults_back: assert property (cfg_reset |=> !cfg_reset ##[0:2] back_to_defaults)
    else $error("settings not back to defaults after reinit");
  chk_lock_select: assert property (csn_held |-> ##[0:8] i2c_locked)
    else $error("select low did not lock out the two-wire bus");
  chk_lock_sticky: assert property (i2c_locked |=> i2c_locked)
    else $error("two-wire lock fell before reset");
  chk_i2c_low_only: assert property (serial_data_pin_oe && !i2c_locked |-> !serial_data_pin_o)
    else $error("data line driven high in two-wire mode");
  chk_out_spi4: assert property (address_select_pin_oe |-> i2c_locked && !spi3_mode)
    else $error("output pin driven outside four-wire reads");
  chk_data_spi3: assert property (serial_data_pin_oe && i2c_locked |-> spi3_mode)
    else $error("data line driven in four-wire mode");
endmodule

bind shi_top shi_top_sva #(.BASE_CYC(BASE_CYC)) u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .chip_select_pin(chip_select_pin),
  .serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe(serial_data_pin_oe),
  .address_select_pin_oe(address_select_pin_oe), .odr_prescale(odr_prescale),
  .iir_coef(iir_coef), .iir_bypass(iir_bypass), .fifo_flush(fifo_flush),
  .cfg_reset(cfg_reset), .i2c_locked(i2c_locked), .spi3_mode(spi3_mode));

//--- sim/shi_host.sv
// host master model driving the serial pins
module shi_host (
  // clock and line readback
  input  wire clk_sys,
  input  wire sd_w,
  input  wire ad_w,
  input  wire three_wire,
  // driven pins
  output reg  scl,
  output reg  sd,
  output reg  csn,
  output reg  ad
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sd = 1'b1;
    csn = 1'b1;
    ad = 1'b0;
  end
  // ------
  // two-wire bus, 160 ns bit; device answer settles ~60 ns after the fall
  // ------
  task i2c_start;
    begin
      #80 sd = 1'b1;
      #80 scl = 1'b1;
      #160 sd = 1'b0;
      #160 scl = 1'b0;
    end
  endtask
  task i2c_stop;
    begin
      #80 sd = 1'b0;
      #80 scl = 1'b1;
      #160 sd = 1'b1;
      #160;
    end
  endtask
  task i2c_bit(input b, output r);
    begin
      #40 sd = b;
      #40 scl = 1'b1;
      #40 r = sd_w;
      #40 scl = 1'b0;
    end
  endtask
  task i2c_byte(input [7:0] tx, input last, output [7:0] rx, output ack);
    integer k;
    reg     r;
    begin
      for (k = 7; k >= 0; k = k - 1)
      begin
        i2c_bit(tx[k], r);
        rx[k] = r;
      end
      i2c_bit(last, r);
      ack = ~r;
    end
  endtask
  // ------
  // four-wire or three-wire bus, 160 ns clock
  // ------
  // clock level set before select falls
  task spi_begin(input m);
    begin
      scl = m;
      #80 csn = 1'b0;
      #80;
    end
  endtask
  task spi_byte(input [7:0] tx, output [7:0] rx);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
      begin
        scl = 1'b0;
        #40 sd = tx[k];
        ad = ~ad;
        #40 scl = 1'b1;
        rx[k] = three_wire ? sd_w : ad_w;
        #80;
      end
    end
  endtask
  task spi_end(input m);
    begin
      scl = m;
      #80 csn = 1'b1;
      sd = ~sd;
      #160;
    end
  endtask
endmodule

//--- sim/shi_top_tb_top.sv
// self-checking bench for the sensor host interface block
`include "shi_map.vh"
module shi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam integer BASE_CYC = 10;
  // ------
  // signals
  // ------
  reg         clk_sys = 1'b0;
  reg         rstn = 1'b0;
  reg         three_wire = 1'b0;
  wire        scl, host_sd, csn, host_ad, sd_w, ad_w, sd_o, sd_oe, ad_o, ad_oe;
  wire [17:0] odr_prescale;
  wire [6:0]  iir_coef;
  wire        sample_tick, iir_bypass, fifo_flush, cfg_reset;
  wire        i2c_locked, spi_mode_11, spi3_mode;
  integer     num_errors = 0;
  integer     samples_checked = 0;
  integer     flushes = 0;
  integer     resets = 0;
  integer     i, m, n;
  reg [7:0]   rd;
  reg         ack;
  always #5 clk_sys = ~clk_sys;
  // open-drain data line: device drive wins, else host level
  assign sd_w = sd_oe ? sd_o : host_sd;
  assign ad_w = ad_oe ? ad_o : host_ad;
  // pulses counted mid-cycle, where they are settled
  always @(negedge clk_sys)
  begin
    if (fifo_flush === 1'b1) flushes = flushes + 1;
    if (cfg_reset === 1'b1) resets = resets + 1;
  end
  shi_top #(.BASE_CYC(BASE_CYC)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .serial_clk_pin(scl), .serial_data_pin_i(sd_w),
    .serial_data_pin_o(sd_o), .serial_data_pin_oe(sd_oe), .chip_select_pin(csn),
    .address_select_pin_i(ad_w), .address_select_pin_o(ad_o),
    .address_select_pin_oe(ad_oe), .odr_prescale(odr_prescale), .sample_tick(sample_tick),
    .iir_coef(iir_coef), .iir_bypass(iir_bypass), .fifo_flush(fifo_flush),
    .cfg_reset(cfg_reset), .i2c_locked(i2c_locked), .spi_mode_11(spi_mode_11),
    .spi3_mode(spi3_mode));
  shi_host h (
    .clk_sys(clk_sys), .sd_w(sd_w), .ad_w(ad_w), .three_wire(three_wire),
    .scl(scl), .sd(host_sd), .csn(csn), .ad(host_ad));
  // ------
  // tasks
  // ------
  task compare(input [17:0] got, input [17:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task i2c_wr2(input [6:0] sa, input [31:0] b, input exp);
    begin
      @(negedge clk_sys);
      h.i2c_start;
      h.i2c_byte({sa, 1'b0}, 1'b1, rd, ack);
      compare(ack, exp);
      for (i = 3; i >= 0; i = i - 1)
      begin
        h.i2c_byte(b[8*i+:8], 1'b1, rd, ack);
        compare(ack, exp);
      end
      h.i2c_stop;
    end
  endtask
  task i2c_rd3(input [6:0] sa, input [7:0] r, input [23:0] e);
    begin
      @(negedge clk_sys);
      h.i2c_start;
      h.i2c_byte({sa, 1'b0}, 1'b1, rd, ack);
      h.i2c_byte(r, 1'b1, rd, ack);
      h.i2c_start;
      h.i2c_byte({sa, 1'b1}, 1'b1, rd, ack);
      compare(ack, 1'b1);
      for (i = 2; i >= 0; i = i - 1)
      begin
        h.i2c_byte(8'hFF, i == 0, rd, ack);
        compare(rd, e[8*i+:8]);
      end
      h.i2c_stop;
    end
  endtask
  task spi_wr(input md, input [6:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      h.spi_begin(md);
      h.spi_byte({1'b0, a}, rd);
      h.spi_byte(d, rd);
      h.spi_end(md);
    end
  endtask
  task spi_rd2(input md, input [6:0] a, input [15:0] e);
    begin
      @(negedge clk_sys);
      h.spi_begin(md);
      h.spi_byte({1'b1, a}, rd);
      h.spi_byte(8'h5A, rd);
      for (i = 1; i >= 0; i = i - 1)
      begin
        h.spi_byte(8'hA5, rd);
        compare(rd, e[8*i+:8]);
      end
      h.spi_end(md);
    end
  endtask
  task wait_tick;
    begin
      n = 0;
      do
      begin
        @(negedge clk_sys);
        n = n + 1;
      end
      while (sample_tick !== 1'b1 && n < 5000);
    end
  endtask
  // ------
  // tests
  // ------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    repeat (10) @(negedge clk_sys);
    compare(odr_prescale, 18'h0_0001);
    i2c_wr2(7'h76, 32'h1D07_1F06, 1'b1);
    compare(odr_prescale, 18'h0_0080);
    compare(iir_coef, 7'h07);
    h.ad = 1'b1;
    i2c_rd3(7'h77, 8'h1D, 24'h07_0006);
    i2c_wr2(7'h76, 32'h1F00_1F00, 1'b0);
    compare(iir_coef, 7'h07);
    $display("test two-wire done");
    h.csn = 1'b0;
    repeat (20) @(negedge clk_sys);
    h.csn = 1'b1;
    repeat (10) @(negedge clk_sys);
    compare(i2c_locked, 1'b1);
    i2c_wr2(7'h77, 32'h1F00_1F00, 1'b0);
    compare(iir_coef, 7'h07);
    $display("test lock done");
    for (m = 0; m < 2; m = m + 1)
    begin
      for (n = 0; n < 8; n = n + 1)
      begin
        spi_wr(m[0], 7'h1F, 8'(n << 1));
        compare(iir_coef, (18'h0_0001 << n) - 18'h0_0001);
        compare(iir_bypass, n == 0);
        compare(spi_mode_11, m[0]);
      end
    end
    for (m = 0; m < 19; m = m + 1)
    begin
      spi_wr(1'b1, 7'h1D, 8'(m));
      compare(odr_prescale, 18'h0_0001 << (m > 17 ? 17 : m));
    end
    spi_wr(1'b1, 7'h1D, 8'h01);
    wait_tick;
    wait_tick;
    wait_tick;
    compare(18'(n), 18'(2 * BASE_CYC));
    $display("test settings done");
    spi_wr(1'b0, 7'h1D, 8'h05);
    spi_wr(1'b0, 7'h1F, 8'h0A);
    spi_rd2(1'b0, 7'h1D, 16'h0500);
    spi_rd2(1'b1, 7'h1E, 16'h000A);
    spi_wr(1'b1, 7'h7E, 8'h34);
    compare(odr_prescale, 18'h0_0020);
    spi_rd2(1'b1, 7'h7E, 16'h0000);
    spi_wr(1'b1, 7'h7E, `SHI_CMD_FLUSH);
    compare(flushes, 1);
    compare(iir_coef, 7'h1F);
    spi_wr(1'b1, 7'h1A, 8'h01);
    compare(spi3_mode, 1'b1);
    three_wire = 1'b1;
    spi_rd2(1'b0, 7'h1D, 16'h0500);
    spi_wr(1'b1, 7'h7E, `SHI_CMD_SRST);
    compare(resets, 1);
    compare(spi3_mode, 1'b0);
    three_wire = 1'b0;
    spi_rd2(1'b1, 7'h1D, 16'h0000);
    compare(iir_bypass, 1'b1);
    $display("test commands done");
    rstn = 1'b0;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (10) @(negedge clk_sys);
    compare(i2c_locked, 1'b0);
    i2c_wr2(7'h77, 32'h1F0E_1D02, 1'b1);
    compare(iir_coef, 7'h7F);
    compare(odr_prescale, 18'h0_0004);
    $display("test reset done");
    print_verdict;
  end
  initial
  begin
    #600000;
    num_errors = num_errors + 1;
    print_verdict;
  end
endmodule
